// *** pkg/irq_gate_pkg.sv ***
/*
 * Shared constants for the interrupt enable gating block: register offsets,
 * field positions, writable and reset masks.
 * Assumes an AHB-Lite slave with 32-bit data, one word per register.
 */
`default_nettype none
package irq_gate_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // byte offsets of the two register views
    localparam logic [ADDR_W-1:0] OFS_ENABLE_SET = 8'h88;
    localparam logic [ADDR_W-1:0] OFS_ENABLE_CLEAR = 8'h8C;

    // field positions
    localparam int BIT_GLOBAL_IRQ_GATE = 31;
    localparam int BIT_MAKER_PRIVATE_EVENT = 30;
    localparam int BIT_SOFTWARE_TRIGGERED_EVENT = 29;
    localparam int BIT_TIMED_RECEIVE_SUMMARY = 7;

    // implemented bits: all but 28 and 14..10
    localparam logic [DATA_W-1:0] ENABLE_WRITABLE = 32'hEFFF_83FF;
    // reset value: undefined bits are taken as 0 as well
    localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h0000_0000;
    // bits that gate an event at the same position (every implemented bit but 31)
    localparam logic [DATA_W-1:0] EVENT_GATED = 32'h6FFF_83FF;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [2:0] HSIZE_WORD = 3'b010;
    localparam logic HRESP_OKAY = 1'b0;
endpackage : irq_gate_pkg
`default_nettype wire

// *** hw/host_interrupt_mask_gating.sv ***
/*
 * Interrupt enable register with set and clear views, and the gate that
 * drives the external interrupt from the event vector.
 * Assumes a single AHB-Lite master, word transfers, and an event vector
 * plus per-context receive events supplied by neighbouring logic.
 */
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module host_interrupt_mask_gating #(
    parameter int RX_CONTEXTS = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [irq_gate_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [irq_gate_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic [irq_gate_pkg::DATA_W-1:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [irq_gate_pkg::DATA_W-1:0] event_bits,
    input wire logic [RX_CONTEXTS-1:0] rx_context_events,
    input wire logic [RX_CONTEXTS-1:0] rx_context_enables,
    output logic [irq_gate_pkg::DATA_W-1:0] enable_mask,
    output logic irq_out
);
    import irq_gate_pkg::*;

    // the receive summary is one OR tree; more than a word of contexts is not served
    if (RX_CONTEXTS < 1 || RX_CONTEXTS > 32) begin : g_bad_rx_contexts
        $error("RX_CONTEXTS out of range");
    end

    logic [DATA_W-1:0] enable_q;
    logic wr_pend_q;
    logic wr_clear_q;
    logic take;
    logic hit_set;
    logic hit_clear;
    logic [DATA_W-1:0] events_eff;
    logic [DATA_W-1:0] pending;

    function automatic logic is_word(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        is_word = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction : is_word

    // zero-wait slave: every transfer finishes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    assign take = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == HSIZE_WORD);
    assign hit_set = is_word(haddr, OFS_ENABLE_SET);
    assign hit_clear = is_word(haddr, OFS_ENABLE_CLEAR);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_clear_q <= 1'b0;
        end else begin
            wr_pend_q <= take && hwrite && (hit_set || hit_clear);
            wr_clear_q <= hit_clear;
        end
    end

    // write-one semantics, zeros leave bits alone; reserved bits never store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q <= ENABLE_RESET;
        end else if (wr_pend_q) begin
            if (wr_clear_q) begin
                enable_q <= enable_q & ~(hwdata & ENABLE_WRITABLE);
            end else begin
                enable_q <= enable_q | (hwdata & ENABLE_WRITABLE);
            end
        end
    end

    // read data registered; unmapped words read as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (take && !hwrite) begin
            if (hit_set || hit_clear) begin
                hrdata <= enable_q & ENABLE_WRITABLE;
            end else begin
                hrdata <= '0;
            end
        end
    end

    // receive summary comes straight from the contexts, not a latched copy
    always_comb begin
        events_eff = event_bits;
        events_eff[BIT_TIMED_RECEIVE_SUMMARY] = |(rx_context_events & rx_context_enables);
    end

    // same-position gating for the implemented bits among 30..0 (not 28, 14..10), bit 31 gates the whole output
    assign pending = events_eff & enable_q & EVENT_GATED;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= enable_q[BIT_GLOBAL_IRQ_GATE] && (|pending);
        end
    end

    assign enable_mask = enable_q & ENABLE_WRITABLE;
endmodule : host_interrupt_mask_gating
`default_nettype wire

// *** sim/irq_gate_asserts.sv ***
/* checker for the gating block; bound to its top ports */
`timescale 1ns/1ps
`default_nettype none
module irq_gate_asserts
    import irq_gate_pkg::*;
#(parameter int RX_CONTEXTS = 8) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [DATA_W-1:0] event_bits,
    input wire logic [RX_CONTEXTS-1:0] rx_context_events,
    input wire logic [RX_CONTEXTS-1:0] rx_context_enables,
    input wire logic [DATA_W-1:0] enable_mask,
    input wire logic irq_out
);
    logic rx_any;
    logic want;
    assign rx_any = |(rx_context_events & rx_context_enables);
    assign want = enable_mask[31] & (|({event_bits[31:8], rx_any, event_bits[6:0]}
        & enable_mask & EVENT_GATED));
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_irq; irq_out == $past(want); endproperty
    a_irq: assert property (p_irq) else $error("irq");
    property p_gate; !enable_mask[31] |=> !irq_out; endproperty
    a_gate: assert property (p_gate) else $error("gate");
    property p_b28; enable_mask[28] == 1'b0; endproperty
    a_b28: assert property (p_b28) else $error("b28");
    property p_b14; enable_mask[14:10] == 5'h00; endproperty
    a_b14: assert property (p_b14) else $error("b14");
    property p_mk; &{enable_mask[31:30], event_bits[30]} |=> irq_out; endproperty
    a_mk: assert property (p_mk) else $error("mk");
    property p_sw; &{enable_mask[31], enable_mask[29], event_bits[29]} |=> irq_out; endproperty
    a_sw: assert property (p_sw) else $error("sw");
    property p_rx; enable_mask[31] && enable_mask[7] && rx_any |=> irq_out; endproperty
    a_rx: assert property (p_rx) else $error("rx");
    property p_rst; $rose(hresetn) |-> (enable_mask & 32'h3804_7C00) == 32'h0; endproperty
    a_rst: assert property (p_rst) else $error("rst");
endmodule : irq_gate_asserts
bind host_interrupt_mask_gating irq_gate_asserts #(.RX_CONTEXTS(RX_CONTEXTS)) i_chk (
    .hclk(hclk), .hresetn(hresetn), .event_bits(event_bits), .irq_out(irq_out),
    .rx_context_events(rx_context_events), .rx_context_enables(rx_context_enables),
    .enable_mask(enable_mask));
`default_nettype wire

// *** sim/tb.sv ***
/* random set/clear/read traffic and events; assumes the package and checker */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import irq_gate_pkg::*;
    logic hclk = 0, hresetn = 0, hwrite = 0, irq_out, hreadyout, hresp;
    logic [7:0] haddr = 0, rxe = 0, rxn = 0;
    logic [1:0] htrans = 0;
    logic [31:0] hwdata = 0, hrdata, event_bits = 0, enable_mask, m = 0, d, v, r;
    logic [31:0] seed = 32'h9EA2_7EAB;
    int bad_count = 0, checked = 0, cycles = 0;
    always #12.5 hclk = ~hclk;
    host_interrupt_mask_gating i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .event_bits(event_bits), .rx_context_events(rxe), .rx_context_enables(rxn),
        .enable_mask(enable_mask), .irq_out(irq_out));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [7:0] a);
        @(posedge hclk);
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic give_verdict();
        $display("mismatches %0d, compares %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        d = 32'hFFFF_FFFF;
        xfer(0, OFS_ENABLE_SET);
        chk(r, m);
        xfer(1, 8'h90);
        xfer(0, 8'h90);
        chk(r | enable_mask, m);
        for (int i = 0; i < 80; i++) begin
            v = rnd();
            d = rnd();
            xfer(1, v[0] ? OFS_ENABLE_SET : OFS_ENABLE_CLEAR);
            m = v[0] ? m | (d & ENABLE_WRITABLE) : m & ~d;
            xfer(0, v[1] ? OFS_ENABLE_SET : OFS_ENABLE_CLEAR);
            chk(r, m);
            chk({hreadyout, hresp}, {1'b1, HRESP_OKAY});
            event_bits <= rnd();
            {rxe, rxn} <= v[15:0];
            repeat (2) @(posedge hclk);
            #1 d = {event_bits[31:8], |(rxe & rxn), event_bits[6:0]};
            chk(irq_out, m[31] & |(d & m & EVENT_GATED));
        end
        give_verdict();
    end
endmodule : tb
`default_nettype wire
